//--- rtl/io_expander_serial_target_port.sv
// serial target port of a 16-bit expander: two-wire target and four-wire target
// assumes an external register file: it takes wr_req on wr_valid, serves rd_data
// combinationally for rd_sel, and latches the port pins on port_sample
`timescale 1ns/100ps
module io_expander_serial_target_port
	import io_expander_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       link_clk,
	input  wire logic       mode_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       strap_hi_or_select_c,
	input  wire logic       strap_mid_or_select_b,
	input  wire logic       strap_low_or_select_a,
	input  wire logic       strap_lsb_or_data_out_in,
	output logic            strap_lsb_or_data_out_out,
	output logic            strap_lsb_or_data_out_oe,
	output reg_write_s      wr_req,
	output logic            wr_valid,
	output logic [2:0]      rd_sel,
	input  wire logic [7:0] rd_data,
	output logic            port_sample
);

	// ---------------- system domain: synchronisers and filters ----------------
	logic [8:0] raw_in;          // pins and link toggles entering sys_clk
	logic [8:0] synced;          // their synchronised images
	logic       scl_f;           // filtered two-wire clock
	logic       sda_f;           // filtered two-wire data
	logic       scl_d_r;         // previous filtered clock
	logic       sda_d_r;         // previous filtered data
	logic       mode_s;          // synchronised mode strap
	logic [3:0] strap_s;         // synchronised address straps
	logic       wr_tog_s;        // synchronised link write toggle
	logic       rd_tog_s;        // synchronised link read toggle
	logic       wr_tog_d_r;      // previous write toggle
	logic       rd_tog_d_r;      // previous read toggle
	logic [6:0] own_addr;        // strapped bus address

	// link domain state; frame registers clear whenever the link is deselected, toggles and holds only on reset
	logic       frame_clear;     // asynchronous clear of the link frame registers
	logic [3:0] spi_pos_r;       // bit position inside the sixteen-bit frame
	logic [2:0] spi_sel_r;       // register select being received
	logic       spi_read_r;      // current frame is a read
	logic [7:0] spi_data_r;      // write data being received
	reg_write_s spi_wr_hold_r;   // completed write, stable for the sys side
	logic       spi_wr_tog_r;    // flips once per completed write
	logic       spi_rd_tog_r;    // flips once per read request
	logic [7:0] spi_tx_r;        // read data shifter on the falling edge
	logic [7:0] spi_rd_hold_r;   // read byte fetched by the sys side

	// two-wire state
	i2c_state_e i2c_state_r;     // sequence state
	logic [3:0] bit_cnt_r;       // bits seen in the current byte
	logic [7:0] shift_r;         // receive and transmit shifter
	logic       rw_r;            // latched read/write bit
	logic [2:0] ptr_r;           // register pointer
	logic       ctl_ack_r;       // controller acknowledged the read byte
	logic [1:0] spi_fetch_r;     // read fetch pipeline for the link side

	logic       scl_rise;        // filtered clock rising
	logic       scl_fall;        // filtered clock falling
	logic       start_seen;      // start condition
	logic       stop_seen;       // stop condition
	logic       i2c_wr_go;       // two-wire write commits this cycle
	logic       i2c_smp_go;      // two-wire pin sample this cycle
	logic       spi_wr_go;       // link write arrives this cycle
	logic       spi_rd_go;       // link read request arrives this cycle

	// returns 1 when a select names one of the read-only input registers
	function automatic logic is_input_sel(input logic [2:0] sel);
		return (sel == SEL_INPUT0) || (sel == SEL_INPUT1);
	endfunction

	assign raw_in = {scl_in, sda_in, strap_hi_or_select_c, strap_mid_or_select_b,
		strap_low_or_select_a, strap_lsb_or_data_out_in, mode_in, spi_wr_tog_r, spi_rd_tog_r};

	sync_two_flop #(
		.WIDTH     (9),
		.RESET_VAL (9'h180)
	) u_sync (
		.clk      (sys_clk),
		.rst      (reset),
		.async_in (raw_in),
		.sync_out (synced)
	);

	assign mode_s   = synced[2];
	assign strap_s  = synced[6:3];
	assign wr_tog_s = synced[1];
	assign rd_tog_s = synced[0];

	glitch_filter u_scl_filter (
		.clk    (sys_clk),
		.rst    (reset),
		.din    (synced[8]),
		.dout_r (scl_f)
	);

	glitch_filter u_sda_filter (
		.clk    (sys_clk),
		.rst    (reset),
		.din    (synced[7]),
		.dout_r (sda_f)
	);

	assign own_addr = BASE_ADDR | {3'h0, strap_s};

	// edge history of the filtered lines and link toggles
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			scl_d_r    <= 1'b1;
			sda_d_r    <= 1'b1;
			wr_tog_d_r <= 1'b0;
			rd_tog_d_r <= 1'b0;
		end else begin
			scl_d_r    <= scl_f;
			sda_d_r    <= sda_f;
			wr_tog_d_r <= wr_tog_s;
			rd_tog_d_r <= rd_tog_s;
		end
	end

	assign scl_rise   = scl_f & ~scl_d_r;
	assign scl_fall   = ~scl_f & scl_d_r;
	assign start_seen = scl_f & scl_d_r & sda_d_r & ~sda_f;
	assign stop_seen  = scl_f & scl_d_r & ~sda_d_r & sda_f;
	// the link only matters in four-wire mode; toggles are ignored otherwise
	assign spi_wr_go  = mode_s & (wr_tog_s ^ wr_tog_d_r);
	assign spi_rd_go  = mode_s & (rd_tog_s ^ rd_tog_d_r);

	assign i2c_wr_go  = (i2c_state_r == I_WDATA_ACK) & scl_rise;
	assign i2c_smp_go = scl_rise & (((i2c_state_r == I_ADDR_ACK) & rw_r) |
		((i2c_state_r == I_RDATA_ACK) & ~sda_f));

	// ---------------- two-wire sequence ----------------
	// one process owns state, counter, shifter, pointer and the data line drive
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			i2c_state_r <= I_IDLE;
			bit_cnt_r   <= 4'h0;
			shift_r     <= 8'h00;
			rw_r        <= 1'b0;
			ptr_r       <= SEL_RESET;
			ctl_ack_r   <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (mode_s) begin
			i2c_state_r <= I_IDLE;
			sda_oe      <= 1'b0;
		end else if (stop_seen) begin
			i2c_state_r <= I_IDLE;
			sda_oe      <= 1'b0;
		end else if (start_seen) begin
			// a repeated start also lands here, pointer kept
			i2c_state_r <= I_ADDR;
			bit_cnt_r   <= 4'h0;
			sda_oe      <= 1'b0;
		end else begin
			case (i2c_state_r)
				I_IDLE: begin
					sda_oe <= 1'b0;
				end
				I_ADDR, I_REG, I_WDATA: begin
					// receive: sample on rise, answer on the fall after the eighth bit
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == I2C_BYTE_BITS) begin
						bit_cnt_r <= 4'h0;
						if (i2c_state_r == I_ADDR) begin
							if (shift_r[7:1] == own_addr) begin
								sda_oe      <= 1'b1;
								rw_r        <= shift_r[0];
								i2c_state_r <= I_ADDR_ACK;
							end else begin
								i2c_state_r <= I_IDLE;
							end
						end else if (i2c_state_r == I_REG) begin
							ptr_r       <= shift_r[2:0];
							sda_oe      <= 1'b1;
							i2c_state_r <= I_REG_ACK;
						end else begin
							sda_oe      <= 1'b1;
							i2c_state_r <= I_WDATA_ACK;
						end
					end
				end
				I_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						if (rw_r) begin
							shift_r     <= rd_data;
							sda_oe      <= ~rd_data[7];
							i2c_state_r <= I_RDATA;
						end else begin
							sda_oe      <= 1'b0;
							i2c_state_r <= I_REG;
						end
					end
				end
				I_REG_ACK: begin
					if (scl_fall) begin
						sda_oe      <= 1'b0;
						i2c_state_r <= I_WDATA;
					end
				end
				I_WDATA_ACK: begin
					if (scl_rise) begin
						ptr_r <= {ptr_r[2:1], ~ptr_r[0]};
					end
					if (scl_fall) begin
						sda_oe      <= 1'b0;
						i2c_state_r <= I_WDATA;
					end
				end
				I_RDATA: begin
					if (scl_rise) begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_r == I2C_BYTE_BITS) begin
							// release for the controller's acknowledge
							sda_oe      <= 1'b0;
							bit_cnt_r   <= 4'h0;
							i2c_state_r <= I_RDATA_ACK;
						end else begin
							shift_r <= {shift_r[6:0], 1'b0};
							sda_oe  <= ~shift_r[6];
						end
					end
				end
				I_RDATA_ACK: begin
					if (scl_rise) begin
						ctl_ack_r <= ~sda_f;
						if (!sda_f) begin
							ptr_r <= {ptr_r[2:1], ~ptr_r[0]};
						end
					end else if (scl_fall) begin
						if (ctl_ack_r) begin
							shift_r     <= rd_data;
							sda_oe      <= ~rd_data[7];
							i2c_state_r <= I_RDATA;
						end else begin
							sda_oe      <= 1'b0;
							i2c_state_r <= I_IDLE;
						end
					end
				end
				default: begin
					i2c_state_r <= I_IDLE;
					sda_oe      <= 1'b0;
				end
			endcase
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge sys_clk) begin
		sda_out <= 1'b0;
	end

	// ---------------- register file hand-off ----------------
	// writes from either interface; one cycle pulse on wr_valid
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_req   <= '0;
			wr_valid <= 1'b0;
		end else if (i2c_wr_go) begin
			wr_req   <= '{sel: ptr_r, data: shift_r};
			wr_valid <= ~is_input_sel(ptr_r);
		end else if (spi_wr_go) begin
			// hold register is stable: the next frame needs sixteen more edges
			wr_req   <= spi_wr_hold_r;
			wr_valid <= ~is_input_sel(spi_wr_hold_r.sel);
		end else begin
			wr_valid <= 1'b0;
		end
	end

	// read select and pin sample pulse for either interface
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_sel      <= SEL_RESET;
			port_sample <= 1'b0;
			spi_fetch_r <= 2'h0;
		end else begin
			spi_fetch_r <= {spi_fetch_r[0], spi_rd_go};
			if (i2c_smp_go) begin
				rd_sel      <= (i2c_state_r == I_RDATA_ACK) ? {ptr_r[2:1], ~ptr_r[0]} : ptr_r;
				port_sample <= 1'b1;
			end else if (spi_rd_go) begin
				// select captured in the link domain is stable since its toggle
				rd_sel      <= spi_sel_r;
				port_sample <= 1'b1;
			end else if (!mode_s && i2c_state_r == I_IDLE) begin
				// idle: show the pointer so a new read starts where the write left it
				rd_sel      <= ptr_r;
				port_sample <= 1'b0;
			end else begin
				port_sample <= 1'b0;
			end
		end
	end

	// byte handed to the link two cycles after the sample, once the file has latched
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			spi_rd_hold_r <= 8'h00;
		end else if (spi_fetch_r[1]) begin
			spi_rd_hold_r <= rd_data;
		end
	end

	// ---------------- link domain (four-wire target) ----------------
	// selected only when all low
	assign frame_clear = strap_hi_or_select_c | strap_mid_or_select_b | strap_low_or_select_a | ~mode_in;

	// clock and data used unfiltered
	// receive side: position counter, select, direction, data
	always_ff @(posedge link_clk or posedge frame_clear) begin
		if (frame_clear) begin
			spi_pos_r  <= 4'h0;
			spi_sel_r  <= 3'h0;
			spi_read_r <= 1'b0;
			spi_data_r <= 8'h00;
		end else begin
			spi_pos_r <= spi_pos_r + 4'h1;
			if (spi_pos_r < SPI_RW_POS) begin
				spi_sel_r <= {spi_sel_r[1:0], sda_in};
			end
			if (spi_pos_r == SPI_RW_POS) begin
				// a low direction bit asks for a read
				spi_read_r <= ~sda_in;
			end
			spi_data_r <= {spi_data_r[6:0], sda_in};
		end
	end

	// event toggles survive deselection, so they are not cleared with the frame;
	// reset parks them at the level the system-side edge detectors start from,
	// otherwise they would never leave the unknown state; link clock is idle in reset
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			spi_rd_tog_r  <= 1'b0;
			spi_wr_tog_r  <= 1'b0;
			spi_wr_hold_r <= '0;
		end else begin
			if (!frame_clear && spi_pos_r == SPI_RW_POS && !sda_in) begin
				spi_rd_tog_r <= ~spi_rd_tog_r;
			end
			if (!frame_clear && spi_pos_r == SPI_LAST_POS && !spi_read_r) begin
				spi_wr_hold_r <= '{sel: spi_sel_r, data: {spi_data_r[6:0], sda_in}};
				spi_wr_tog_r  <= ~spi_wr_tog_r;
			end
		end
	end

	always_ff @(negedge link_clk or posedge frame_clear) begin
		if (frame_clear) begin
			spi_tx_r                  <= 8'h00;
			strap_lsb_or_data_out_out <= 1'b0;
			strap_lsb_or_data_out_oe  <= 1'b0;
		end else if (spi_read_r && spi_pos_r == SPI_DATA_POS) begin
			// fetched byte has had four link periods to settle
			spi_tx_r                  <= {spi_rd_hold_r[6:0], 1'b0};
			strap_lsb_or_data_out_out <= spi_rd_hold_r[7];
			strap_lsb_or_data_out_oe  <= 1'b1;
		end else if (spi_read_r && spi_pos_r > SPI_DATA_POS) begin
			spi_tx_r                  <= {spi_tx_r[6:0], 1'b0};
			strap_lsb_or_data_out_out <= spi_tx_r[7];
		end else begin
			// falling edge after the last bit ends the drive
			strap_lsb_or_data_out_oe  <= 1'b0;
		end
	end

endmodule

//--- rtl/io_expander_pkg.sv
// constants, carriers and state codes shared by the expander serial target port
// assumes a 50 MHz system clock; the spi link clock arrives on its own pin
package io_expander_pkg;

	localparam int          CLK_PERIOD_NS  = 20;                                      // system clock period
	localparam int          GLITCH_NS      = 50;                                      // shortest pulse passed
	localparam int          GLITCH_CYCLES  = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  GLITCH_LIMIT   = 2'(GLITCH_CYCLES - 1);                   // counter end value
	localparam logic [6:0]  BASE_ADDR      = 7'h20;                                   // address with all straps low
	localparam logic [2:0]  SEL_INPUT0     = 3'h0;                                    // input port 0 select
	localparam logic [2:0]  SEL_INPUT1     = 3'h1;                                    // input port 1 select
	localparam logic [2:0]  SEL_RESET      = 3'h0;                                    // pointer after reset
	localparam logic [3:0]  I2C_BYTE_BITS  = 4'h8;                                    // bits in a byte
	localparam logic [3:0]  SPI_RW_POS     = 4'h3;                                    // frame position of write bit
	localparam logic [3:0]  SPI_DATA_POS   = 4'h8;                                    // first data position
	localparam logic [3:0]  SPI_LAST_POS   = 4'hF;                                    // last data position

	// one register write handed to the register file
	typedef struct packed {
		logic [2:0] sel;
		logic [7:0] data;
	} reg_write_s;

	// two-wire target sequence
	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WDATA, I_WDATA_ACK, I_RDATA, I_RDATA_ACK
	} i2c_state_e;

endpackage

//--- rtl/sync_two_flop.sv
// two flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level or a toggle; words are not kept coherent
`timescale 1ns/100ps
module sync_two_flop
	import io_expander_pkg::*;
#(
	parameter int         WIDTH     = 1,
	parameter logic [8:0] RESET_VAL = 9'h000
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r; // first stage, read only by the second

	// both stages run every edge; reset parks them at the idle level
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r   <= RESET_VAL[WIDTH-1:0];
			sync_out <= RESET_VAL[WIDTH-1:0];
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

//--- rtl/glitch_filter.sv
// digital glitch filter: output follows input only after it has been stable
// assumes the input is already synchronised to clk
`timescale 1ns/100ps
module glitch_filter
	import io_expander_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout_r
);

	logic [1:0] stable_r; // cycles the input has differed from the output

	// a change must persist for the full count before it is passed on
	always_ff @(posedge clk) begin
		if (rst) begin
			dout_r   <= 1'b1;
			stable_r <= 2'h0;
		end else if (din == dout_r) begin
			stable_r <= 2'h0;
		end else if (stable_r == GLITCH_LIMIT) begin
			dout_r   <= din;
			stable_r <= 2'h0;
		end else begin
			stable_r <= stable_r + 2'h1;
		end
	end

endmodule

//--- bench/io_port_monitor.sv
// checker for the expander serial target port, system clock domain only
// assumes it is bound to the top module and sees nothing but its ports
`timescale 1ns/100ps
module io_port_monitor
	import io_expander_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       mode_in,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic       strap_hi_or_select_c,
	input wire logic       strap_mid_or_select_b,
	input wire logic       strap_low_or_select_a,
	input wire logic       strap_lsb_or_data_out_oe,
	input wire reg_write_s wr_req,
	input wire logic       wr_valid,
	input wire logic [2:0] rd_sel,
	input wire logic       port_sample
);
	// all checks sample on the system clock; all but the reset check sleep through reset
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_no_input;
		wr_valid |-> wr_req.sel != SEL_INPUT0 && wr_req.sel != SEL_INPUT1;
	endproperty
	a_no_input: assert property (p_no_input) else $error("write issued to an input register");
	property p_wr_space;
		$rose(wr_valid) |=> !wr_valid [*8];
	endproperty
	a_wr_space: assert property (p_wr_space) else $error("write pulse too long or too close");
	property p_i2c_quiet;
		!mode_in |-> !strap_lsb_or_data_out_oe;
	endproperty
	a_i2c_quiet: assert property (p_i2c_quiet) else $error("data out driven in two-wire mode");
	// mode is synchronised, so give the two-wire side a few cycles to go idle
	property p_spi_no_sda;
		mode_in && $past(mode_in, 8) |-> !sda_oe;
	endproperty
	a_spi_no_sda: assert property (p_spi_no_sda) else $error("data line pulled in four-wire mode");
	property p_deselect;
		(strap_hi_or_select_c | strap_mid_or_select_b | strap_low_or_select_a) |-> !strap_lsb_or_data_out_oe;
	endproperty
	a_deselect: assert property (p_deselect) else $error("data out driven while deselected");
	// the target may only move the data line while the clock is low
	property p_changed;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_changed: assert property (p_changed) else $error("data line moved while clock high");
	property p_sample;
		port_sample && !mode_in |-> scl_in && $past(scl_in, 2);
	endproperty
	a_sample: assert property (p_sample) else $error("port sample away from a clock high");
	property p_wr_at_ack;
		wr_valid && !mode_in |-> scl_in && $past(scl_in, 2);
	endproperty
	a_wr_at_ack: assert property (p_wr_at_ack) else $error("write away from the ack clock high");
	// reset itself is the cause here, so this one is never disabled
	property p_reset;
		disable iff (1'b0) reset |=> rd_sel == SEL_RESET && !sda_oe && !wr_valid && !port_sample;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind io_expander_serial_target_port io_port_monitor u_mon (
	.sys_clk(sys_clk), .reset(reset), .mode_in(mode_in), .scl_in(scl_in), .sda_oe(sda_oe),
	.strap_hi_or_select_c(strap_hi_or_select_c), .strap_mid_or_select_b(strap_mid_or_select_b),
	.strap_low_or_select_a(strap_low_or_select_a), .strap_lsb_or_data_out_oe(strap_lsb_or_data_out_oe),
	.wr_req(wr_req), .wr_valid(wr_valid), .rd_sel(rd_sel), .port_sample(port_sample)
);

//--- bench/io_ctrl_model.sv
// controller model: two-wire bit transfers and four-wire frames
// assumes the bench resolves the shared pins from the drives below
`timescale 1ns/100ps
module io_ctrl_model (
	input  wire logic       sys_clk,
	input  wire logic       sda_line,
	input  wire logic       miso,
	output logic            clk_pin,
	output logic            sda_drv,
	output logic [2:0]      sel_n
);
	logic glitch;  // adds 40 ns pulses on both lines when set

	// bus idles released, nothing selected
	initial begin
		clk_pin = 1'b1;
		sda_drv = 1'b1;
		sel_n   = 3'h7;
		glitch  = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// data moves while clock low; sampled mid-high
	task automatic i_bit(input logic b, output logic r);
		sda_drv = b;
		w(4);
		clk_pin = glitch;  // short false clock, must be filtered out
		w(2);
		clk_pin = 1'b0;
		w(4);
		clk_pin = 1'b1;
		w(10);
		r = sda_line;
		sda_drv = glitch ? ~b : b;  // short false start or stop
		w(2);
		sda_drv = b;
		w(8);
		clk_pin = 1'b0;
		w(10);
	endtask

	task automatic i_start();
		sda_drv = 1'b1;
		w(10);
		clk_pin = 1'b1;
		w(10);
		sda_drv = 1'b0;
		w(10);
		clk_pin = 1'b0;
		w(10);
	endtask

	task automatic i_stop();
		sda_drv = 1'b0;
		w(10);
		clk_pin = 1'b1;
		w(10);
		sda_drv = 1'b1;
		w(10);
	endtask

	// reads pass 8'hFF so the line is released; ak high refuses
	task automatic i_byte(input logic [7:0] b, input logic ak, output logic [7:0] r, output logic ka);
		for (int i = 7; i >= 0; i--)
			i_bit(b[i], r[i]);
		i_bit(ak, ka);
	endtask

	// 45 ns period, stretched from 15 ns to stay under 25 MHz
	task automatic s_frame(input logic [2:0] cs, input logic [15:0] word, output logic [7:0] rd);
		clk_pin = 1'b0;
		sel_n = cs;
		#30;
		for (int i = 15; i >= 0; i--) begin
			sda_drv = word[i];
			#22.5;
			if (i < 8)
				rd[i] = miso;
			clk_pin = 1'b1;
			#22.5;
			clk_pin = 1'b0;
		end
		#30;
		sel_n = 3'h7;
		sda_drv = ~sda_drv;  // stale data must not look held
	endtask
endmodule

//--- bench/io_expander_serial_target_port_test.sv
// self-checking bench for the expander serial target port
// assumes the controller model above and a stub register file kept here
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module io_expander_serial_target_port_test;
	import io_expander_pkg::*;
	logic       sys_clk, reset, mode_in, sda_out, sda_oe, miso_out, miso_oe, wr_valid, port_sample;
	logic       clk_pin, sda_drv, sda_line, miso_line;
	logic [2:0] sel_n, rd_sel;
	logic [3:0] strap;           // two-wire address straps
	logic [7:0] regs [8];        // stub register file contents
	reg_write_s wr_req, exp_w;
	reg_write_s q [$];           // expected writes, oldest first
	int         n_fail, comparisons, cycles, n_smp;

	// open-drain data line with pull-up; released data out pulled up too
	assign sda_line  = mode_in ? sda_drv : sda_drv & ~(sda_oe & ~sda_out);
	assign miso_line = miso_oe ? miso_out : 1'b1;

	io_expander_serial_target_port DUT (
		.sys_clk(sys_clk), .reset(reset), .link_clk(clk_pin), .mode_in(mode_in), .scl_in(clk_pin),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.strap_hi_or_select_c(mode_in ? sel_n[2] : strap[3]),
		.strap_mid_or_select_b(mode_in ? sel_n[1] : strap[2]),
		.strap_low_or_select_a(mode_in ? sel_n[0] : strap[1]),
		.strap_lsb_or_data_out_in(mode_in ? miso_line : strap[0]),
		.strap_lsb_or_data_out_out(miso_out), .strap_lsb_or_data_out_oe(miso_oe),
		.wr_req(wr_req), .wr_valid(wr_valid), .rd_sel(rd_sel), .rd_data(regs[rd_sel]),
		.port_sample(port_sample)
	);
	io_ctrl_model ctl (
		.sys_clk(sys_clk), .sda_line(sda_line), .miso(miso_line),
		.clk_pin(clk_pin), .sda_drv(sda_drv), .sel_n(sel_n)
	);

	// 50 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// hang guard: the run needs about 7400 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			final_report();
		end
	end

	// each write pulse takes the oldest note; an unexpected one meets x
	// looked at mid-cycle, where the one-cycle pulse has settled
	always @(negedge sys_clk) begin
		if (!reset && wr_valid === 1'b1) begin
			exp_w = q.size() ? q.pop_front() : 'x;
			`CHK("wr_req", exp_w, wr_req)
		end
	end

	// pin sample pulses, one per acknowledge ahead of a read byte
	always @(negedge sys_clk) begin
		if (!reset && port_sample === 1'b1)
			n_smp++;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic test_end(input string s);
		$display("test %s done", s);
	endtask

	// one controller byte with the acknowledge compared
	task automatic xb(input logic [7:0] b, input logic ak_exp);
		logic [7:0] r;
		logic       ka;
		ctl.i_byte(b, 1'b1, r, ka);
		`CHK("ack", ak_exp, ka)
	endtask

	initial begin
		logic [7:0] r, d0, d1;
		logic [6:0] a;
		logic       ka;
		reset = 1'b1;
		mode_in = 1'b0;
		strap = 4'h0;
		n_fail = 0;
		comparisons = 0;
		cycles = 0;
		void'($urandom(32'hAC37));
		foreach (regs[i])
			regs[i] = 8'($urandom());
		repeat (4) @(negedge sys_clk);
		reset = 1'b0;
		repeat (5) @(negedge sys_clk);
		// double write at a random and the top strap; glitches on the first pass
		for (int k = 0; k < 2; k++) begin
			strap = k ? 4'hF : 4'($urandom());
			a = BASE_ADDR | 7'(strap);
			d0 = 8'($urandom());
			d1 = 8'($urandom());
			ctl.glitch = (k == 0);
			q.push_back({3'h2, d0});
			q.push_back({3'h3, d1});
			repeat (20) @(negedge sys_clk);
			ctl.i_start();
			xb({a, 1'b0}, 1'b0);
			xb(8'h02, 1'b0);
			xb(d0, 1'b0);
			xb(d1, 1'b0);
			ctl.i_stop();
		end
		ctl.glitch = 1'b0;
		test_end("write");
		// foreign address ignored; input registers swallow writes
		ctl.i_start();
		xb({a ^ 7'h01, 1'b0}, 1'b1);
		ctl.i_stop();
		ctl.i_start();
		xb({a, 1'b0}, 1'b0);
		xb(8'h00, 1'b0);
		xb(8'($urandom()), 1'b0);
		xb(8'($urandom()), 1'b0);
		ctl.i_stop();
		test_end("ignore");
		// select, repeated start, alternating bytes, refused ack ends it
		ctl.i_start();
		xb({a, 1'b0}, 1'b0);
		xb(8'h05, 1'b0);
		ctl.i_start();
		xb({a, 1'b1}, 1'b0);
		for (int j = 0; j < 3; j++) begin
			ctl.i_byte(8'hFF, j == 2, r, ka);
			`CHK("rd", regs[j == 1 ? 4 : 5], r)
		end
		`CHK("sda_oe", 1'b0, sda_oe)
		`CHK("port_sample", 3, n_smp)
		ctl.i_stop();
		test_end("read");
		// reset in mid-run clears the pointer
		repeat (3) @(negedge sys_clk);
		reset = 1'b1;
		repeat (4) @(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
		`CHK("rd_sel", SEL_RESET, rd_sel)
		repeat (5) @(negedge sys_clk);
		test_end("reset");
		// four-wire: write, refused write with one select high, read
		mode_in = 1'b1;
		repeat (10) @(negedge sys_clk);
		d0 = 8'($urandom());
		q.push_back({3'h6, d0});
		ctl.s_frame(3'h0, {3'h6, 5'h10, d0}, r);
		ctl.s_frame(3'h2, {3'h7, 5'h10, d0}, r);
		`CHK("miso_oe", 1'b0, miso_oe)
		ctl.s_frame(3'h0, {3'h4, 5'h00, 8'h00}, r);
		`CHK("spi_rd", regs[4], r)
		`CHK("miso_oe", 1'b0, miso_oe)
		repeat (10) @(negedge sys_clk);
		`CHK("pending", 0, q.size())
		test_end("four_wire");
		final_report();
	end
endmodule
